// ===== dpm_cfg.svh
// Constants for the debug pin mux and boot select block
// Assumes inclusion by the pin mux module only
`ifndef DPM_CFG_SVH
`define DPM_CFG_SVH
`define DPM_BOOT_CHECK_ADDR 20'h80014
`define DPM_BOOT_ERASED     32'hffffffff
`define DPM_PIN_COUNT       4
`define DPM_SYNC_DEPTH      3
`define DPM_FN_GPIO         2'h0
`define DPM_FN_DEBUG        2'h1
`define DPM_FN_ALT          2'h2
`define DPM_FN_ARRAY        2'h3
`define DPM_BOOT_TIMEOUT_NS 1000
`define DPM_CLK_PERIOD_NS   50
`define DPM_BOOT_TIMEOUT_CYC ((`DPM_BOOT_TIMEOUT_NS + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS)
`endif

// ===== dpm_pkg.sv
// Types for the debug pin mux and boot select block
// Assumes nothing beyond the constants header
package dpm_pkg;
   typedef enum logic [1:0] {
      DPM_BOOT_UNKNOWN,
      DPM_BOOT_DOWNLOAD,
      DPM_BOOT_USER
   } dpm_boot_t;
   typedef logic [1:0] dpm_fn_t;
endpackage

// ===== dpm_sync.sv
// Three-stage pin synchroniser with agreement filter
// Assumes an asynchronous input and one clock
`timescale 1ns/1ps
module dpm_sync (
   input  wire logic CLK,
   input  wire logic RST,
   input  wire logic IN_PIN,
   output logic      OUT_LVL
);
   logic [2:0] stage;
   wire        agree = (stage[1] == stage[2]);
   always_ff @(posedge CLK) begin
      if (RST) begin
         stage   <= 3'h0;
         OUT_LVL <= 1'b0;
      end else begin
         stage <= {stage[1:0], IN_PIN};
         if (agree)
            OUT_LVL <= stage[2];
      end
   end
endmodule

// ===== dpm_pin_mux.sv
// Port-0 pins 0..3 function mux, test port gating and boot decision
// Assumes a flash word reader answers with a valid pulse, and port regs from a bus elsewhere
`timescale 1ns/1ps
`include "dpm_cfg.svh"
module dpm_pin_mux (
   input  wire logic             CORE_CLK,
   input  wire logic             RST,
   input  wire logic             RESET_PIN_N,
   input  wire logic [3:0]       PIN_IN,
   output logic      [3:0]       PIN_OUT,
   output logic      [3:0]       PIN_OE,
   input  wire logic [7:0]       PORT0_CONFIG_REG,
   input  wire logic [3:0]       PORT0_DATA_REG,
   input  wire logic [3:0]       PORT0_DIR_REG,
   output logic      [3:0]       PORT0_READ,
   input  wire logic             CONVERTER_BUSY,
   input  wire logic [9:8]       LOGIC_ARRAY_OUTPUT,
   output logic      [9:8]       LOGIC_ARRAY_INPUT,
   input  wire logic             TEST_DATA_OUT,
   input  wire logic             TEST_DATA_OUT_EN,
   output logic                  TEST_DATA_IN,
   output logic                  TEST_CLOCK,
   output logic                  TEST_PORT_RESET_N,
   output logic                  DEBUG_ENABLED,
   output logic                  FLASH_READ_REQ,
   output logic      [19:0]      FLASH_ADDR,
   input  wire logic [31:0]      FLASH_DATA,
   input  wire logic             FLASH_VALID,
   output logic                  BOOT_DONE,
   output logic                  DOWNLOAD_MODE,
   output logic                  RUN_USER_CODE,
   output dpm_pkg::dpm_boot_t    BOOT_MODE
);
   import dpm_pkg::*;

   logic [3:0] pin_sync;
   logic       rst_sync;
   logic       strap;
   logic       strap_taken;
   logic       debug_lost;
   logic [7:0] cfg_seen;
   logic [3:0] dat_seen;
   logic [3:0] dir_seen;
   dpm_boot_t  boot;
   dpm_boot_t  next_boot;

   // Synchronise the four pins and the reset pin
   genvar g;
   generate
      for (g = 0; g < `DPM_PIN_COUNT; g = g + 1) begin : gen_sync
         dpm_sync u_sync (
            .CLK     (CORE_CLK),
            .RST     (RST),
            .IN_PIN  (PIN_IN[g]),
            .OUT_LVL (pin_sync[g])
         );
      end
   endgenerate
   dpm_sync u_rst_sync (
      .CLK     (CORE_CLK),
      .RST     (RST),
      .IN_PIN  (RESET_PIN_N),
      .OUT_LVL (rst_sync)
   );

   wire hold     = RST | ~rst_sync;
   wire trst_n   = pin_sync[0];
   wire bit0_gpio = (PORT0_CONFIG_REG[1:0] == `DPM_FN_GPIO);
   wire dbg_pins = strap_taken & strap;
   wire dbg_live = dbg_pins & trst_n & bit0_gpio & ~debug_lost;
   wire cfg_touched = (PORT0_CONFIG_REG[7:2] != cfg_seen[7:2]) ||
                      (PORT0_DATA_REG[3:1] != dat_seen[3:1]) ||
                      (PORT0_DIR_REG[3:1] != dir_seen[3:1]);
   wire bit1_gpio = ~dbg_live;
   wire bit2_gpio = ~dbg_live;
   wire bit3_gpio = ~dbg_live;
   wire b0_busy  = (PORT0_CONFIG_REG[1:0] == `DPM_FN_ALT);
   wire b2_arr   = (PORT0_CONFIG_REG[5:4] == `DPM_FN_ARRAY);
   wire b3_arr   = (PORT0_CONFIG_REG[7:6] == `DPM_FN_ARRAY);
   wire [3:0] next_out = {b3_arr ? LOGIC_ARRAY_OUTPUT[9] : PORT0_DATA_REG[3],
                          b2_arr ? LOGIC_ARRAY_OUTPUT[8] : PORT0_DATA_REG[2],
                          bit1_gpio ? PORT0_DATA_REG[1] : TEST_DATA_OUT,
                          b0_busy ? CONVERTER_BUSY : PORT0_DATA_REG[0]};
   wire [3:0] next_oe = {bit3_gpio & (PORT0_DIR_REG[3] | b3_arr),
                         bit2_gpio & (PORT0_DIR_REG[2] | b2_arr),
                         bit1_gpio ? PORT0_DIR_REG[1] : TEST_DATA_OUT_EN,
                         PORT0_DIR_REG[0] | b0_busy};
   wire flash_erased = (FLASH_DATA == `DPM_BOOT_ERASED);

   // Boot decision
   always_comb begin
      next_boot = boot;
      case (boot)
         DPM_BOOT_UNKNOWN: begin
            if (strap_taken && strap)
               next_boot = DPM_BOOT_USER;
            else if (strap_taken && FLASH_VALID)
               next_boot = flash_erased ? DPM_BOOT_DOWNLOAD : DPM_BOOT_USER;
         end
         DPM_BOOT_DOWNLOAD: next_boot = DPM_BOOT_DOWNLOAD;
         DPM_BOOT_USER:     next_boot = DPM_BOOT_USER;
         default:           next_boot = DPM_BOOT_UNKNOWN;
      endcase
   end

   // Strap capture once after release
   always_ff @(posedge CORE_CLK) begin
      if (hold) begin
         strap_taken <= 1'b0;
         strap       <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         strap       <= pin_sync[0];
      end
   end

   // Debug loss tracking
   always_ff @(posedge CORE_CLK) begin
      if (hold) begin
         debug_lost <= 1'b0;
         cfg_seen   <= 8'h00;
         dat_seen   <= 4'h0;
         dir_seen   <= 4'h0;
      end else begin
         cfg_seen <= PORT0_CONFIG_REG;
         dat_seen <= PORT0_DATA_REG;
         dir_seen <= PORT0_DIR_REG;
         if (dbg_live && strap_taken && cfg_touched)
            debug_lost <= 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (hold)
         boot <= DPM_BOOT_UNKNOWN;
      else
         boot <= next_boot;
   end

   // Next values of the registered outputs
   wire [3:0] next_read   = {pin_sync[3:2], bit1_gpio & pin_sync[1], pin_sync[0]};
   wire [9:8] next_arr_in = {pin_sync[1], pin_sync[0]};
   wire       next_tdi    = dbg_live & pin_sync[2];
   wire       next_tck    = dbg_live & pin_sync[3];
   wire       next_req    = strap_taken & ~strap & (boot == DPM_BOOT_UNKNOWN) & ~FLASH_VALID;
   wire       next_done   = (next_boot != DPM_BOOT_UNKNOWN);
   wire       next_dl     = (next_boot == DPM_BOOT_DOWNLOAD);
   wire       next_run    = (next_boot == DPM_BOOT_USER);

   // Pad drive and enables
   always_ff @(posedge CORE_CLK) begin
      if (hold) begin
         PIN_OUT <= 4'h0;
         PIN_OE  <= 4'h0;
      end else begin
         PIN_OUT <= next_out;
         PIN_OE  <= next_oe;
      end
   end

   // Pad read back and array inputs
   always_ff @(posedge CORE_CLK) begin
      if (hold) begin
         PORT0_READ        <= 4'h0;
         LOGIC_ARRAY_INPUT <= 2'h0;
      end else begin
         PORT0_READ        <= next_read;
         LOGIC_ARRAY_INPUT <= next_arr_in;
      end
   end

   // Test port side
   always_ff @(posedge CORE_CLK) begin
      if (hold) begin
         TEST_DATA_IN      <= 1'b0;
         TEST_CLOCK        <= 1'b0;
         TEST_PORT_RESET_N <= 1'b0;
         DEBUG_ENABLED     <= 1'b0;
      end else begin
         TEST_DATA_IN      <= next_tdi;
         TEST_CLOCK        <= next_tck;
         TEST_PORT_RESET_N <= dbg_live;
         DEBUG_ENABLED     <= dbg_live;
      end
   end

   // Boot-check read request
   always_ff @(posedge CORE_CLK) begin
      if (hold) begin
         FLASH_READ_REQ <= 1'b0;
         FLASH_ADDR     <= `DPM_BOOT_CHECK_ADDR;
      end else begin
         FLASH_READ_REQ <= next_req;
         FLASH_ADDR     <= `DPM_BOOT_CHECK_ADDR;
      end
   end

   // Boot results, held until the next reset
   always_ff @(posedge CORE_CLK) begin
      if (hold) begin
         BOOT_DONE     <= 1'b0;
         DOWNLOAD_MODE <= 1'b0;
         RUN_USER_CODE <= 1'b0;
         BOOT_MODE     <= DPM_BOOT_UNKNOWN;
      end else begin
         BOOT_DONE     <= next_done;
         DOWNLOAD_MODE <= next_dl;
         RUN_USER_CODE <= next_run;
         BOOT_MODE     <= next_boot;
      end
   end
endmodule

// ===== dpm_flash_model.sv
// Flash word reader answering the boot-check request
// Assumes a request level held until the valid pulse
`timescale 1ns/1ps
module dpm_flash_model (
   input  wire logic        clk, req,
   input  wire logic [3:0]  lat,
   input  wire logic [19:0] addr,
   input  wire logic [31:0] word,
   output logic             valid = 1'b0,
   output logic      [31:0] data = 32'h0
);
   logic [3:0] cnt = 4'h0;
   always @(posedge clk) begin
      valid <= req && !valid && cnt >= lat;
      data  <= (req && !valid && cnt >= lat && addr == 20'h80014) ? word : ~word;
      cnt   <= (req && !valid && cnt < lat) ? cnt + 4'h1 : 4'h0;
   end
endmodule

// ===== dpm_monitor.sv
// Checker of the pin mux and boot select ports
// Assumes binding onto each dpm_pin_mux instance
`timescale 1ns/1ps
module dpm_monitor (
   input wire logic               CORE_CLK, RST, RESET_PIN_N, CONVERTER_BUSY, TEST_DATA_OUT, DEBUG_ENABLED,
   input wire logic               FLASH_READ_REQ, FLASH_VALID, BOOT_DONE, DOWNLOAD_MODE, RUN_USER_CODE,
   input wire logic [3:0]         PIN_OUT, PIN_OE,
   input wire logic [7:0]         PORT0_CONFIG_REG,
   input wire logic [19:0]        FLASH_ADDR,
   input wire logic [31:0]        FLASH_DATA,
   input wire dpm_pkg::dpm_boot_t BOOT_MODE
);
   import dpm_pkg::*;
   logic [5:0] hist;
   wire        rst_any = RST || !RESET_PIN_N || !(&hist);
   always_ff @(posedge CORE_CLK) hist <= {hist[4:0], RESET_PIN_N & !RST};
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (rst_any);
   sequence s_erased_word;
      FLASH_VALID && FLASH_DATA == 32'hffffffff;
   endsequence
   a_addr_fixed: assert property (FLASH_ADDR == 20'h80014)
      else $error("bad address");
   a_request_held: assert property (FLASH_READ_REQ && !FLASH_VALID |=> FLASH_READ_REQ)
      else $error("request dropped");
   a_download_sel: assert property (s_erased_word ##1 $rose(BOOT_DONE)
      |-> DOWNLOAD_MODE && BOOT_MODE == DPM_BOOT_DOWNLOAD) else $error("no download");
   a_user_sel: assert property ($rose(BOOT_DONE) && !DOWNLOAD_MODE |-> RUN_USER_CODE
      && BOOT_MODE == DPM_BOOT_USER && !($past(FLASH_VALID) && $past(FLASH_DATA) == 32'hffffffff))
      else $error("bad user boot");
   a_result_hold: assert property (BOOT_DONE |=> BOOT_DONE && $stable(BOOT_MODE))
      else $error("boot result moved");
   a_tdo_drive: assert property (DEBUG_ENABLED && $past(DEBUG_ENABLED) |-> PIN_OUT[1] == $past(TEST_DATA_OUT))
      else $error("bad test data out");
   a_busy_route: assert property ($past(PORT0_CONFIG_REG[1:0]) == 2'h2
      |-> PIN_OE[0] && PIN_OUT[0] == $past(CONVERTER_BUSY)) else $error("bad busy route");
   a_debug_lost: assert property (DEBUG_ENABLED && $changed(PORT0_CONFIG_REG) |-> ##[1:2] !DEBUG_ENABLED)
      else $error("debug kept");
endmodule
bind dpm_pin_mux dpm_monitor mon (.*);

// ===== tb_top.sv
// Bench for boot choice and pin defaults of the pin mux
// Assumes the flash model and the checker compile first
`timescale 1ns/1ps
module tb_top;
   import dpm_pkg::*;
   logic        clk = 0, rst = 1, rpn = 1, busy = 0, tdo = 0, seen = 0, req, valid, de, done, dl, ru;
   logic        tdoe = 1, tdi, tck, tprn;
   logic [1:0]  lao = 0, lai;
   logic [3:0]  pin = 0, dat = 0, dir = 0, lat = 0, pout, poe, rd;
   logic [7:0]  cfg = 0;
   logic [19:0] fa;
   logic [31:0] word = 0, fd, lf = 32'h75ac;
   dpm_boot_t   mode;
   logic [4:0]  expq[$];
   int          miscompares = 0, n_tests = 0;
   always #25 clk = ~clk;
   dpm_pin_mux DUT (.CORE_CLK(clk), .RST(rst), .RESET_PIN_N(rpn), .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE(poe),
      .PORT0_CONFIG_REG(cfg), .PORT0_DATA_REG(dat), .PORT0_DIR_REG(dir), .PORT0_READ(rd), .CONVERTER_BUSY(busy),
      .LOGIC_ARRAY_OUTPUT(lao), .LOGIC_ARRAY_INPUT(lai), .TEST_DATA_OUT(tdo), .TEST_DATA_OUT_EN(tdoe),
      .TEST_DATA_IN(tdi), .TEST_CLOCK(tck), .TEST_PORT_RESET_N(tprn), .DEBUG_ENABLED(de), .FLASH_READ_REQ(req),
      .FLASH_ADDR(fa), .FLASH_DATA(fd), .FLASH_VALID(valid), .BOOT_DONE(done), .DOWNLOAD_MODE(dl),
      .RUN_USER_CODE(ru), .BOOT_MODE(mode));
   dpm_flash_model flash (.clk(clk), .req(req), .lat(lat), .addr(fa), .word(word), .valid(valid), .data(fd));
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string name, input logic [4:0] e, input logic [4:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s: expected %h, seen %h", name, e, g);
      end
   endtask
   task automatic stir(input logic wide);
      repeat (12) begin
         @(negedge clk);
         lf = lfsr_next(lf);
         {busy, lao, tdo, pin[3:1]} = lf[6:0];
         tdoe = lf[16];
         if (wide) {pin[0], dat, dir} = lf[15:7];
      end
   endtask
   task automatic boot(input logic s, input logic [31:0] w, input logic p);
      pin = {3'h0, s};
      word = w;
      lat = lf[3:0];
      cfg = 8'h00;
      dat = 4'h0;
      dir = 4'h0;
      tdoe = 1'b1;
      rst = !p;
      rpn = !p;
      repeat (8) @(negedge clk);
      {rst, rpn} = 2'b01;
      expq.push_back((s || w !== 32'hffffffff) ? {3'b001, DPM_BOOT_USER} : {3'b010, DPM_BOOT_DOWNLOAD});
      for (int k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk);
      repeat (4) @(negedge clk);
      chk("debug and enables", {s, 2'b00, s, 1'b0}, {de, poe});
      stir(1'b0);
      repeat (5) @(negedge clk);
      chk("array and test inputs", {pin[1:0], s & pin[2], s & pin[3], s}, {lai, tdi, tck, tprn});
      chk("port read", {1'b0, pin[3:2], !s & pin[1], pin[0]}, {1'b0, rd});
      pin[0] = 1'b0;
      repeat (5) @(negedge clk);
      chk("debug with test reset low", 5'h00, {2'b00, de, tprn, poe[1]});
      pin[0] = s;
      repeat (5) @(negedge clk);
      chk("debug after test reset", {2'b00, s, s, s & tdoe}, {2'b00, de, tprn, poe[1]});
      cfg = 8'h04;
      @(negedge clk);
      cfg = 8'h00;
      repeat (3) @(negedge clk);
      chk("debug after change", 5'h00, {4'h0, de});
      cfg = 8'h32;
      stir(1'b1);
      @(negedge clk);
      chk("pad drive", {1'b0, dat[3], lao[0], dat[1], busy}, {1'b0, pout});
      chk("pad enables", {1'b0, dir[3], 1'b1, dir[1], 1'b1}, {1'b0, poe});
   endtask
   always @(negedge clk) begin
      if (done === 1'b1 && !seen && expq.size() > 0) chk("boot", expq.pop_front(), {1'b0, dl, ru, mode});
      seen <= done === 1'b1;
   end
   task automatic conclude();
      miscompares += expq.size();
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 6; i++) begin
         lf = lfsr_next(lf);
         boot(i == 0 || i == 3, (i % 3 == 1 || i == 3) ? 32'hffffffff : (i == 5 ? 32'hfffffffe : lf), i == 3 || i == 4);
         $display("test %0d finished", i);
      end
      conclude();
   end
   initial begin
      #(50 * 3000);
      miscompares++;
      conclude();
   end
endmodule
